/* pbw_pkg.sv */
// shared constants, states and helper functions for the push-button wiper control
// assumes a single 20 MHz clock; every interval is counted in 1 ms ticks
`default_nettype none
package pbw_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;

    // intervals in milliseconds, as documented
    localparam int DEBOUNCE_INTERVAL_MS = 15;
    localparam int SLOW_REPEAT_INTERVAL_MS = 250;
    localparam int FAST_REPEAT_INTERVAL_MS = 50;
    localparam int FAST_AFTER_MS = 1000;
    localparam int SHUTDOWN_HOLD_MS = 2000;

    // the same intervals in ticks
    localparam logic [3:0] DEBOUNCE_TICKS = 4'(DEBOUNCE_INTERVAL_MS * MS_NS / TICK_TIME_NS);
    localparam logic [8:0] SLOW_TICKS = 9'(SLOW_REPEAT_INTERVAL_MS * MS_NS / TICK_TIME_NS);
    localparam logic [8:0] FAST_TICKS = 9'(FAST_REPEAT_INTERVAL_MS * MS_NS / TICK_TIME_NS);
    localparam logic [10:0] FAST_AFTER_TICKS = 11'(FAST_AFTER_MS * MS_NS / TICK_TIME_NS);
    localparam logic [10:0] SHUTDOWN_TICKS = 11'(SHUTDOWN_HOLD_MS * MS_NS / TICK_TIME_NS);

    // tap counter
    localparam logic [3:0] TAP_RESET = 4'h0;
    localparam logic [3:0] TAP_MAX = 4'hf;
    localparam logic [3:0] TAP_BOTTOM = 4'h0;

    typedef enum logic [2:0] {
        PBW_IDLE = 3'h0,
        PBW_HOLD = 3'h1,
        PBW_DUAL = 3'h2,
        PBW_SD_WAIT = 3'h3,
        PBW_SHUTDOWN = 3'h4,
        PBW_LOCK = 3'h5
    } pbw_state_t;

    // one step toward the given direction, stopping at either end
    function automatic logic [3:0] pbw_sat_step(input logic [3:0] tap, input logic up);
        if (up) begin
            pbw_sat_step = (tap == TAP_MAX) ? tap : 4'(tap + 4'h1);
        end else begin
            pbw_sat_step = (tap == TAP_BOTTOM) ? tap : 4'(tap - 4'h1);
        end
    endfunction : pbw_sat_step

    // one-hot tap select
    function automatic logic [15:0] pbw_decode(input logic [3:0] tap);
        pbw_decode = 16'h0001 << tap;
    endfunction : pbw_decode
endpackage : pbw_pkg
`default_nettype wire

/* pbw_tick.sv */
// prescaler that turns the system clock into a one-cycle millisecond tick
// assumes P_CYCLES is between 2 and 65536
`default_nettype none
module pbw_tick #(
    parameter int P_CYCLES = pbw_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    output logic o_tick
);
    localparam logic [15:0] LAST = 16'(P_CYCLES - 1);

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic next_tick;

    // free-running divider; tick is registered so consumers see a clean pulse
    always_comb begin
        next_cnt = (cnt == LAST) ? 16'h0000 : 16'(cnt + 16'h0001);
        next_tick = (cnt == LAST);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            o_tick <= next_tick;
        end
    end
endmodule : pbw_tick
`default_nettype wire

/* pbw_debounce.sv */
// two-flop synchroniser and press debounce for one active-low button
// assumes i_tick is a one-cycle pulse every millisecond on i_clk
`default_nettype none
module pbw_debounce (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_tick,
    input wire logic i_button_n,
    output logic o_low,
    output logic o_pressed
);
    logic sync1;
    logic sync2;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_pressed;

    // release acts at once so stepping stops without waiting; only presses are filtered
    always_comb begin
        next_cnt = cnt;
        next_pressed = o_pressed;
        if (sync2) begin
            next_cnt = 4'h0;
            next_pressed = 1'b0;
        end else if (i_tick && cnt != pbw_pkg::DEBOUNCE_TICKS) begin
            next_cnt = 4'(cnt + 4'h1); // [RULE3]
            next_pressed = (4'(cnt + 4'h1) == pbw_pkg::DEBOUNCE_TICKS); // [RULE3]
        end
    end

    // sync1 feeds only sync2; idle high matches the pull-up level
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            cnt <= 4'h0;
            o_pressed <= 1'b0;
        end else begin
            sync1 <= i_button_n; // [RULE19]
            sync2 <= sync1; // [RULE19]
            cnt <= next_cnt;
            o_pressed <= next_pressed;
        end
    end

    assign o_low = ~sync2;
endmodule : pbw_debounce
`default_nettype wire

/* pbw_top.sv */
// push-button wiper control: debounce, stepping, auto-repeat and shutdown of a 16-tap wiper
// assumes raw button pins with pull-ups outside; one 20 MHz clock, asynchronous active-low reset
// Notes on behaviour
// [RULE1] a 4-bit counter holds the tap; up raises, down lowers; decoded to one tap
// [RULE2] buttons idle high; a low press moves the wiper one adjacent tap
// [RULE3] lows shorter than the debounce interval are ignored
// [RULE4] a short press gives one step; holding gives more steps over time
// [RULE5] slow repeat during the first second of hold, fast repeat afterwards
// [RULE6] release stops stepping at once and returns to idle, tap kept
// [RULE7] buttons pressed more than 15 ms apart: ignore all until both released
// [RULE8] the counter saturates at both ends and never wraps
// [RULE9] both buttons low for two seconds enters shutdown
// [RULE10] shutdown opens the top terminal and forces the bottom tap
// [RULE11] the driver must press both within 15 ms to request shutdown
// [RULE12] in shutdown, one button held past the debounce interval exits
// [RULE13] exit restores the tap saved at entry and reconnects the top terminal
// [RULE14] after exit, holding the same button past 250 ms starts auto-repeat
// [RULE15] slow repeat steps every 250 ms
// [RULE16] fast repeat steps every 50 ms
// [RULE17] after reset the tap counter is zero, the bottom tap
// [RULE18] the driver leaves both buttons released 2 ms between separate presses
// [RULE19] inputs are synchronised; all intervals come from a prescaled millisecond tick
// [RULE20] a dual press broken before two seconds changes nothing until both are high
`default_nettype none
module pbw_top #(
    parameter int P_TICK_CYCLES = pbw_pkg::TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_step_up_button_n,
    input wire logic i_step_down_button_n,
    output logic [15:0] o_tap_select,
    output logic [3:0] o_tap,
    output logic o_top_terminal_open
);
    logic tick;
    logic up_low;
    logic dn_low;
    logic up_prs;
    logic dn_prs;

    pbw_pkg::pbw_state_t st;
    pbw_pkg::pbw_state_t next_st;
    logic [3:0] tap;
    logic [3:0] next_tap;
    logic [3:0] saved;
    logic [3:0] next_saved;
    logic [10:0] hold;
    logic [10:0] next_hold;
    logic [8:0] rep;
    logic [8:0] next_rep;
    logic dir_up;
    logic next_dir_up;
    logic top_open;
    logic next_top_open;
    logic [15:0] next_sel;
    logic held;
    logic other;
    logic [8:0] interval;

    // millisecond time base shared by both buttons
    pbw_tick #(
        .P_CYCLES(P_TICK_CYCLES)
    ) u_tick (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .o_tick(tick) // [RULE19]
    );

    pbw_debounce u_up (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .i_button_n(i_step_up_button_n), // [RULE2]
        .o_low(up_low),
        .o_pressed(up_prs)
    );

    pbw_debounce u_dn (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .i_button_n(i_step_down_button_n), // [RULE2]
        .o_low(dn_low),
        .o_pressed(dn_prs)
    );

    // held button, opposite button and the repeat interval for the current hold time
    always_comb begin
        held = dir_up ? up_low : dn_low;
        other = dir_up ? dn_low : up_low;
        interval = (hold >= pbw_pkg::FAST_AFTER_TICKS) ? pbw_pkg::FAST_TICKS // [RULE5] [RULE16]
                                                       : pbw_pkg::SLOW_TICKS; // [RULE15]
    end

    // control sequence; a lone press is only acted on once debounced; a release or a low on the other button acts at once
    always_comb begin
        next_st = st;
        next_tap = tap;
        next_saved = saved;
        next_hold = hold;
        next_rep = rep;
        next_dir_up = dir_up;
        next_top_open = top_open;
        unique case (st)
            pbw_pkg::PBW_IDLE: begin
                if (up_prs || dn_prs) begin
                    if (up_low && dn_low) begin
                        // the other went low before this one debounced: within the window
                        next_st = pbw_pkg::PBW_DUAL; // [RULE9]
                        next_hold = 11'h000;
                    end else begin
                        next_tap = pbw_pkg::pbw_sat_step(tap, up_prs); // [RULE1] [RULE4] [RULE8]
                        next_dir_up = up_prs;
                        next_hold = 11'h000;
                        next_rep = 9'h000;
                        next_st = pbw_pkg::PBW_HOLD;
                    end
                end
            end
            pbw_pkg::PBW_HOLD: begin
                if (!held) begin
                    next_st = pbw_pkg::PBW_IDLE; // [RULE6]
                end else if (other) begin
                    // second press arrived after the first had already debounced
                    next_st = pbw_pkg::PBW_LOCK; // [RULE7]
                end else if (tick) begin
                    if (hold != pbw_pkg::FAST_AFTER_TICKS) begin
                        next_hold = 11'(hold + 11'h001);
                    end
                    if (9'(rep + 9'h001) >= interval) begin
                        next_tap = pbw_pkg::pbw_sat_step(tap, dir_up); // [RULE4] [RULE8] [RULE14]
                        next_rep = 9'h000;
                    end else begin
                        next_rep = 9'(rep + 9'h001);
                    end
                end
            end
            pbw_pkg::PBW_DUAL: begin
                if (!(up_low && dn_low)) begin
                    next_st = pbw_pkg::PBW_LOCK; // [RULE20]
                end else if (tick) begin
                    if (11'(hold + 11'h001) == pbw_pkg::SHUTDOWN_TICKS) begin
                        next_saved = tap; // [RULE13]
                        next_tap = pbw_pkg::TAP_BOTTOM; // [RULE10]
                        next_top_open = 1'b1; // [RULE10]
                        next_st = pbw_pkg::PBW_SD_WAIT; // [RULE9]
                    end else begin
                        next_hold = 11'(hold + 11'h001);
                    end
                end
            end
            pbw_pkg::PBW_SD_WAIT: begin
                // the entering press must end before an exit press can count
                if (!up_low && !dn_low) begin
                    next_st = pbw_pkg::PBW_SHUTDOWN;
                end
            end
            pbw_pkg::PBW_SHUTDOWN: begin
                if ((up_prs && !dn_low) || (dn_prs && !up_low)) begin
                    next_tap = saved; // [RULE12] [RULE13]
                    next_top_open = 1'b0; // [RULE13]
                    next_dir_up = up_prs;
                    next_hold = 11'h000;
                    next_rep = 9'h000;
                    next_st = pbw_pkg::PBW_HOLD; // [RULE14]
                end
            end
            pbw_pkg::PBW_LOCK: begin
                if (!up_low && !dn_low) begin
                    next_st = pbw_pkg::PBW_IDLE; // [RULE7] [RULE20]
                end
            end
            default: begin
                next_st = pbw_pkg::PBW_IDLE;
            end
        endcase
        next_sel = pbw_pkg::pbw_decode(next_tap); // [RULE1]
    end

    // state registers; the select is registered alongside the counter it decodes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= pbw_pkg::PBW_IDLE;
            tap <= pbw_pkg::TAP_RESET; // [RULE17]
            saved <= pbw_pkg::TAP_RESET;
            hold <= 11'h000;
            rep <= 9'h000;
            dir_up <= 1'b0;
            top_open <= 1'b0;
            o_tap_select <= 16'h0001; // [RULE17]
        end else begin
            st <= next_st;
            tap <= next_tap;
            saved <= next_saved;
            hold <= next_hold;
            rep <= next_rep;
            dir_up <= next_dir_up;
            top_open <= next_top_open;
            o_tap_select <= next_sel;
        end
    end

    assign o_tap = tap;
    assign o_top_terminal_open = top_open;

    // checks on the control sequence
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    a_sel_onehot: assert property ($onehot(o_tap_select)) // [RULE1]
        else $error("tap select is not one-hot");

    a_sel_matches: assert property (o_tap_select == pbw_pkg::pbw_decode(tap)) // [RULE1]
        else $error("tap select disagrees with tap counter");

    a_hold_adjacent: assert property ((st == pbw_pkg::PBW_HOLD && $past(st) == pbw_pkg::PBW_HOLD) |-> // [RULE8]
        ({1'b0, tap} == {1'b0, $past(tap)} || {1'b0, tap} == 5'({1'b0, $past(tap)} + 5'h01)
         || {1'b0, tap} == 5'({1'b0, $past(tap)} - 5'h01)))
        else $error("tap moved by more than one step or wrapped");

    // a repeat step may only follow a millisecond tick
    a_step_on_tick: assert property (($past(st) == pbw_pkg::PBW_HOLD && st == pbw_pkg::PBW_HOLD // [RULE19]
        && tap != $past(tap)) |-> $past(tick))
        else $error("repeat step without a tick");

    a_shutdown_bottom: assert property ((st == pbw_pkg::PBW_SHUTDOWN) |-> // [RULE10]
        (tap == pbw_pkg::TAP_BOTTOM && o_tap_select == 16'h0001 && o_top_terminal_open))
        else $error("shutdown without bottom tap and open top terminal");

    a_open_state: assert property (o_top_terminal_open == // [RULE10]
        (st == pbw_pkg::PBW_SD_WAIT || st == pbw_pkg::PBW_SHUTDOWN))
        else $error("top terminal open outside shutdown");

    a_release_idle: assert property ((st == pbw_pkg::PBW_HOLD && !up_low && !dn_low) |=> // [RULE6]
        (st == pbw_pkg::PBW_IDLE && $stable(tap)))
        else $error("release did not stop stepping");

    a_lock_frozen: assert property ((st == pbw_pkg::PBW_LOCK) |=> $stable(tap)) // [RULE7]
        else $error("tap changed while commands are ignored");

    a_dual_break: assert property ((st == pbw_pkg::PBW_DUAL && !(up_low && dn_low)) |=> // [RULE20]
        (st == pbw_pkg::PBW_LOCK && $stable(tap)))
        else $error("broken dual press not rejected");

    a_restore_tap: assert property ((st == pbw_pkg::PBW_SHUTDOWN && next_st == pbw_pkg::PBW_HOLD) |=> // [RULE13]
        (tap == $past(saved) && !o_top_terminal_open))
        else $error("shutdown exit did not restore tap");

    a_enter_shutdown: assert property ((st == pbw_pkg::PBW_DUAL && up_low && dn_low && tick // [RULE9]
        && 11'(hold + 11'h001) == pbw_pkg::SHUTDOWN_TICKS) |=> (st == pbw_pkg::PBW_SD_WAIT
        && tap == pbw_pkg::TAP_BOTTOM && saved == $past(tap)))
        else $error("shutdown not entered after the dual hold");

    // a debounced press in idle moves the wiper exactly one tap toward its button
    a_up_step: assert property ((st == pbw_pkg::PBW_IDLE && up_prs && !dn_low // [RULE2] [RULE4]
        && tap != pbw_pkg::TAP_MAX) |=> ({1'b0, tap} == 5'({1'b0, $past(tap)} + 5'h01)))
        else $error("debounced up press did not step once");

    a_down_step: assert property ((st == pbw_pkg::PBW_IDLE && dn_prs && !up_prs && !up_low // [RULE2] [RULE4]
        && tap != pbw_pkg::TAP_BOTTOM) |=> ({1'b0, tap} == 5'({1'b0, $past(tap)} - 5'h01)))
        else $error("debounced down press did not step once");

    // short lows never reach the press flags, so idle without one must keep the tap
    a_idle_quiet: assert property ((st == pbw_pkg::PBW_IDLE && !up_prs && !dn_prs) |=> $stable(tap)) // [RULE3]
        else $error("tap moved without a debounced press");

    // a second press after the first has debounced locks the controls until both are up
    a_hold_lock: assert property ((st == pbw_pkg::PBW_HOLD && held && other) |=> // [RULE7]
        (st == pbw_pkg::PBW_LOCK && $stable(tap)))
        else $error("late second press not rejected");

    a_lock_exit: assert property ((st == pbw_pkg::PBW_LOCK && !up_low && !dn_low) |=> // [RULE7]
        (st == pbw_pkg::PBW_IDLE))
        else $error("lock not left after both released");

    // both ends hold against further steps in the held direction
    a_top_saturate: assert property ((st == pbw_pkg::PBW_HOLD && dir_up && tap == pbw_pkg::TAP_MAX) |=> // [RULE8]
        (tap == pbw_pkg::TAP_MAX))
        else $error("tap wrapped past the top");

    a_bottom_saturate: assert property ((st == pbw_pkg::PBW_HOLD && !dir_up // [RULE8]
        && tap == pbw_pkg::TAP_BOTTOM) |=> (tap == pbw_pkg::TAP_BOTTOM))
        else $error("tap wrapped past the bottom");

    // the repeat counter never outruns its interval; hold and rep restart together
    a_slow_bound: assert property ((st == pbw_pkg::PBW_HOLD) |-> (rep < pbw_pkg::SLOW_TICKS)) // [RULE15]
        else $error("slow repeat interval overrun");

    a_fast_bound: assert property ((st == pbw_pkg::PBW_HOLD && hold == pbw_pkg::FAST_AFTER_TICKS) |-> // [RULE16]
        (rep < pbw_pkg::FAST_TICKS))
        else $error("fast repeat interval overrun");

    a_hold_ceiling: assert property ((st == pbw_pkg::PBW_HOLD) |-> (hold <= pbw_pkg::FAST_AFTER_TICKS)) // [RULE5]
        else $error("hold counter ran past the fast switch");

    a_dual_count: assert property ((st == pbw_pkg::PBW_DUAL) |-> (hold < pbw_pkg::SHUTDOWN_TICKS)) // [RULE9]
        else $error("dual hold counted past the shutdown time");

    // parked wiper stays at the bottom and the saved tap is untouched until an exit
    a_sd_wait_parked: assert property ((st == pbw_pkg::PBW_SD_WAIT) |=> // [RULE10]
        (tap == pbw_pkg::TAP_BOTTOM && $stable(saved)))
        else $error("parked wiper moved before shutdown settled");

    a_sd_stay: assert property ((st == pbw_pkg::PBW_SHUTDOWN && !up_prs && !dn_prs) |=> // [RULE12]
        (st == pbw_pkg::PBW_SHUTDOWN))
        else $error("shutdown left without a debounced press");

    a_exit_dir: assert property ((st == pbw_pkg::PBW_SHUTDOWN && up_prs && !dn_low) |=> // [RULE14]
        (st == pbw_pkg::PBW_HOLD && dir_up))
        else $error("shutdown exit did not arm the up repeat");
endmodule : pbw_top
`default_nettype wire

/* pbw_button_model.sv */
// two push buttons to ground with the pull-ups of the pins, as seen by the wiper control
// assumes the bench sets i_press_up / i_press_down just after a rising edge of i_clk
`default_nettype none
module pbw_button_model #(
    parameter int P_GAP_CYCLES = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_press_up,
    input wire logic i_press_down,
    output logic o_step_up_button_n,
    output logic o_step_down_button_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic up_was;
    logic dn_was;
    logic [15:0] gap_cnt;
    logic [15:0] next_gap_cnt;
    logic gap_long;
    logic up_ok;
    logic dn_ok;

    // a fresh press waits out the released gap; joining a button still held is not a new event,
    // but moving straight from one button to the other is, so that waits as well
    assign gap_long = (gap_cnt >= 16'(P_GAP_CYCLES));
    assign up_ok = up_was || (i_press_down && dn_was) || gap_long;
    assign dn_ok = dn_was || (i_press_up && up_was) || gap_long;
    // an open contact floats high through the pull-up, so nothing but 1 or 0 is seen
    assign o_step_up_button_n = ~(i_press_up && up_ok);
    assign o_step_down_button_n = ~(i_press_down && dn_ok);

    // released-time counter saturates so a long idle cannot wrap back below the gap
    always_comb begin
        next_gap_cnt = gap_cnt;
        if (!o_step_up_button_n || !o_step_down_button_n) begin
            next_gap_cnt = 16'h0000;
        end else if (gap_cnt != 16'hffff) begin
            next_gap_cnt = 16'(gap_cnt + 16'h0001);
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            up_was <= 1'b0;
            dn_was <= 1'b0;
            gap_cnt <= 16'hffff;
        end else begin
            up_was <= ~o_step_up_button_n;
            dn_was <= ~o_step_down_button_n;
            gap_cnt <= next_gap_cnt;
        end
    end
endmodule : pbw_button_model
`default_nettype wire

/* pbw_top_bench.sv */
// self-checking bench for the push-button wiper control, buttons driven through the model
// assumes a 1 ms tick of 4 clocks, so every documented interval scales by that figure
`default_nettype none
`define PBW_CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module pbw_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TK = 4;
    localparam int LIMIT = 60000;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic press_up = 1'b0;
    logic press_down = 1'b0;
    wire logic up_n;
    wire logic down_n;
    logic [15:0] o_tap_select;
    logic [3:0] o_tap;
    logic o_top_terminal_open;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    pbw_button_model #(.P_GAP_CYCLES(2 * TK)) pbw_button_model_inst (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_press_up(press_up), .i_press_down(press_down),
        .o_step_up_button_n(up_n), .o_step_down_button_n(down_n));
    pbw_top #(.P_TICK_CYCLES(TK)) pbw_top_inst (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_step_up_button_n(up_n), .i_step_down_button_n(down_n), .o_tap_select(o_tap_select),
        .o_tap(o_tap), .o_top_terminal_open(o_top_terminal_open));

    always #25 i_clk = ~i_clk;

    // a hang is cut short here and still reaches the one closing report
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ends 1 ns after an edge so drives land off the sampling edge
    task automatic wait_ms(input int ms);
        repeat (ms * TK) @(posedge i_clk);
        #1;
    endtask : wait_ms

    task automatic wait_change(input int max_cyc, output int cnt);
        logic [3:0] old;
        old = o_tap;
        cnt = 0;
        while (o_tap === old && cnt < max_cyc) begin
            @(posedge i_clk);
            #1;
            cnt++;
        end
    endtask : wait_change

    // one press of a single button, then a released spell longer than the gap
    task automatic press(input logic up, input int ms);
        press_up = up;
        press_down = ~up;
        wait_ms(ms);
        press_up = 1'b0;
        press_down = 1'b0;
        wait_ms(5);
    endtask : press

    task automatic t_reset_values;
        `PBW_CHK("tap", 4'h0, o_tap)
        `PBW_CHK("select", 16'h0001, o_tap_select)
        `PBW_CHK("top_open", 1'b0, o_top_terminal_open)
    endtask : t_reset_values

    task automatic t_glitch_and_steps;
        press(1'b1, 10);
        press(1'b0, 10);
        `PBW_CHK("glitch tap", 4'h0, o_tap)
        press(1'b1, 30);
        `PBW_CHK("single up", 4'h1, o_tap)
        `PBW_CHK("select one", 16'h0002, o_tap_select)
        press(1'b1, 30);
        press(1'b0, 30);
        `PBW_CHK("single down", 4'h1, o_tap)
        press(1'b0, 30);
        press(1'b0, 30);
        `PBW_CHK("bottom stays", 4'h0, o_tap)
    endtask : t_glitch_and_steps

    // slow intervals until the hold reaches a second, fast ones after, then the top end
    task automatic t_repeat;
        press_up = 1'b1;
        wait_change(20 * TK, n);
        `PBW_CHK("first step", 4'h1, o_tap)
        for (int i = 0; i < 4; i++) begin
            wait_change(300 * TK, n);
            `PBW_CHK("slow interval", 1'b1, (n >= 249 * TK && n <= 251 * TK))
        end
        for (int i = 0; i < 3; i++) begin
            wait_change(300 * TK, n);
            `PBW_CHK("fast interval", 1'b1, (n >= 49 * TK && n <= 51 * TK))
        end
        `PBW_CHK("tap after repeats", 4'h8, o_tap)
        // released mid-range so a stepper that kept running would show
        press_up = 1'b0;
        wait_ms(300);
        `PBW_CHK("release stops", 4'h8, o_tap)
        press_up = 1'b1;
        wait_ms(1300);
        `PBW_CHK("top stays", 4'hf, o_tap)
        `PBW_CHK("select top", 16'h8000, o_tap_select)
        press_up = 1'b0;
        wait_ms(5);
        press(1'b0, 12);
        wait_ms(300);
        `PBW_CHK("short press at top", 4'hf, o_tap)
    endtask : t_repeat

    // second button late, and a dual press broken early: both change nothing
    task automatic t_bad_dual;
        press_down = 1'b1;
        wait_ms(30);
        press_up = 1'b1;
        wait_ms(300);
        `PBW_CHK("late dual", 4'he, o_tap)
        press_up = 1'b0;
        press_down = 1'b0;
        wait_ms(5);
        press_up = 1'b1;
        press_down = 1'b1;
        wait_ms(500);
        press_up = 1'b0;
        wait_ms(400);
        `PBW_CHK("broken dual", 4'he, o_tap)
        `PBW_CHK("broken dual top", 1'b0, o_top_terminal_open)
        press_down = 1'b0;
        wait_ms(5);
    endtask : t_bad_dual

    task automatic enter_shutdown;
        press_up = 1'b1;
        press_down = 1'b1;
        wait_ms(1990);
        `PBW_CHK("not yet shut", 1'b0, o_top_terminal_open)
        wait_ms(40);
        `PBW_CHK("shut top", 1'b1, o_top_terminal_open)
        `PBW_CHK("shut tap", 4'h0, o_tap)
        `PBW_CHK("shut select", 16'h0001, o_tap_select)
        press_up = 1'b0;
        press_down = 1'b0;
        wait_ms(5);
    endtask : enter_shutdown

    task automatic t_shutdown;
        enter_shutdown();
        press(1'b1, 10);
        `PBW_CHK("short stays shut", 1'b1, o_top_terminal_open)
        press(1'b0, 20);
        `PBW_CHK("exit top", 1'b0, o_top_terminal_open)
        `PBW_CHK("exit tap", 4'he, o_tap)
        enter_shutdown();
        press_up = 1'b1;
        wait_ms(250);
        `PBW_CHK("held exit tap", 4'he, o_tap)
        `PBW_CHK("held exit top", 1'b0, o_top_terminal_open)
        wait_ms(30);
        `PBW_CHK("repeat after exit", 4'hf, o_tap)
        press_up = 1'b0;
        wait_ms(5);
    endtask : t_shutdown

    initial begin
        repeat (5) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        wait_ms(1);
        t_reset_values();
        t_glitch_and_steps();
        t_repeat();
        t_bad_dual();
        t_shutdown();
        give_verdict();
    end
endmodule : pbw_top_bench
`default_nettype wire
